/* File: include/lbus_pkg.sv */
// Package for the local bus access engine: constants, types and carriers.
// Assumes a single 10 MHz system clock and synchronous active-low reset.
package lbus_pkg;

    localparam int unsigned DATA_W      = 32;
    localparam int unsigned ADDR_W      = 32;
    localparam int unsigned LANES       = 4;
    localparam int unsigned WAIT_W      = 4;
    localparam int unsigned TMR_W       = 16;
    localparam int unsigned GATHER_N    = 4;

    localparam logic [3:0]  WAIT_RESET  = 4'hf;
    localparam logic [15:0] TMR_MAX     = 16'hffff;
    localparam logic [15:0] TMR_ZERO    = 16'h0000;
    localparam logic [3:0]  WAIT_ZERO   = 4'h0;
    localparam logic [1:0]  GATHER_LAST = 2'h3;
    localparam logic [1:0]  ONE_2       = 2'h1;

    // Address space decode: the top three physical address bits pick the space.
    localparam int unsigned SPACE_HI    = 31;
    localparam int unsigned SPACE_LO    = 29;
    localparam logic [2:0]  SPACE_BOOT  = 3'h0;
    localparam logic [2:0]  SPACE_IO    = 3'h1;
    localparam logic [2:0]  SPACE_GLOB  = 3'h2;

    localparam int unsigned BYTE_W      = 8;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_TRI  = 2'h2,
        SZ_WORD = 2'h3
    } access_size_t;

    typedef struct packed {
        logic [31:0]  addr;
        logic         write;
        logic         dma;
        logic         cached;
        logic         ifetch;
        access_size_t size;
        logic         little;
        logic [31:0]  wdata;
    } access_req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        bus_error;
        logic        timeout;
    } access_rsp_t;

    typedef struct packed {
        logic boot;
        logic io;
        logic glob;
    } chip_sel_t;

endpackage : lbus_pkg

/* File: hdl/bus_timer.sv */
// Holds the 16-bit local bus timeout counter.
// Assumes start pulses and the active level from the access engine on the same clock.
`timescale 1ns/100ps
`default_nettype none
module bus_timer (
    input  wire logic ref_clk,    // System clock.
    input  wire logic rst_n,      // Synchronous reset, active low.
    input  wire logic clk_en,     // Freezes all state while low.
    input  wire logic start,      // Access or next gathered beat begins: reload to maximum.
    input  wire logic active,     // Access in progress.
    input  wire logic tmo_en,     // Timeout enable input.
    output logic      expired     // Timer at zero while enabled.
);
    logic [15:0] count_q;
    logic [15:0] count_d;
    wire         at_zero = (count_q == lbus_pkg::TMR_ZERO);
    wire         run     = active && tmo_en && !at_zero;

    assign count_d = start ? lbus_pkg::TMR_MAX
                   : run   ? count_q - 16'h0001
                   : count_q;
    assign expired = active && tmo_en && at_zero;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_q <= lbus_pkg::TMR_MAX;
        end else if (clk_en) begin
            count_q <= count_d;
        end
    end
endmodule // bus_timer
`default_nettype wire

/* File: hdl/lbus_engine.sv */
// Local bus read/write engine: lane strobes, wait states, termination, gathering.
// Assumes requests held stable until done, and external inputs synchronous.
`timescale 1ns/100ps
`default_nettype none
module lbus_engine (
    input  wire logic                  ref_clk,          // System clock, 10 MHz.
    input  wire logic                  rst_n,            // Synchronous reset, active low.
    input  wire logic                  clk_en,           // Freezes all state while low.
    input  wire logic                  req_valid,        // Access request held until done.
    input  wire lbus_pkg::access_req_t req,              // Request fields.
    output logic                       req_done,         // Access finished, one cycle.
    output lbus_pkg::access_rsp_t      rsp,              // Result of finished access.
    input  wire logic                  wait_wr,          // Load new wait count.
    input  wire logic [3:0]            wait_val,         // New wait count.
    output logic [3:0]                 wait_count,       // Current wait count.
    output logic [31:0]                bus_addr,         // Local bus byte address.
    output logic [31:0]                bus_wdata,        // Local bus write data.
    output logic                       bus_data_oe,      // Drives write data.
    input  wire logic [31:0]           bus_rdata,        // Local bus read data.
    output logic [3:0]                 lane_we,          // Lane write strobes.
    output logic                       address_strobe_n, // Access in progress, low.
    output logic                       bus_write,        // Access is a write.
    output logic                       ifetch_access,    // Access is instruction fetch.
    output logic                       rd_oe_n,          // Read output enable, low.
    output lbus_pkg::chip_sel_t        chip_sel_n,       // Decoded selects, low.
    input  wire logic                  data_ready_n,     // Device data ready, low.
    input  wire logic                  wait_en_n,        // Wait timeout enable, low.
    input  wire logic                  bus_error_n,      // Device bus error, low.
    input  wire logic                  timeout_en_n,     // Bus timer enable, low.
    input  wire logic                  byte_wide,        // Byte-wide device mode.
    output logic                       bus_timeout,      // Timeout pin output.
    output logic                       timeout_exc       // Internal timeout exception.
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_BUS  = 3'h2,
        ST_DONE = 3'h4
    } state_t;

    state_t                state_q;
    state_t                state_d;
    logic [3:0]            wait_q;
    logic [3:0]            wcnt_q;
    logic [3:0]            wcnt_d;
    logic [1:0]            beat_q;
    logic [1:0]            beat_d;
    logic [31:0]           gather_q;
    logic [31:0]           gather_d;
    logic [31:0]           addr_q;
    logic [31:0]           addr_d;
    lbus_pkg::access_rsp_t rsp_q;
    lbus_pkg::access_rsp_t rsp_d;
    logic                  gmode_q;
    logic                  tmr_expired;

    // Lane mask for an access of a given size at a given byte offset.
    function automatic logic [3:0] lane_mask(input lbus_pkg::access_size_t sz,
                                             input logic [1:0] off,
                                             input logic little);
        logic [3:0] m;
        m = 4'h0;
        unique case (sz)
            lbus_pkg::SZ_WORD: m = 4'hf;
            lbus_pkg::SZ_TRI:  m = off[0] ? 4'he : 4'h7;
            lbus_pkg::SZ_HALF: m = off[1] ? 4'hc : 4'h3;
            lbus_pkg::SZ_BYTE: m = 4'h1 << off;
        endcase
        // Lane numbering runs the other way for little-endian placement.
        if (little) begin
            m = {m[0], m[1], m[2], m[3]};
        end
        return m;
    endfunction

    // Decoded address space compare, used by every select.
    function automatic logic in_space(input logic [31:0] a, input logic [2:0] sp);
        return a[lbus_pkg::SPACE_HI:lbus_pkg::SPACE_LO] == sp;
    endfunction

    wire start      = (state_q == ST_IDLE) && req_valid;
    wire active     = (state_q == ST_BUS);
    wire gather_req = byte_wide && !req.write && !req.dma && !req.cached;
    wire wait_on    = !wait_en_n;
    wire rdy        = !data_ready_n;
    wire berr       = !bus_error_n;
    wire wait_exp   = wait_on && (wcnt_q == lbus_pkg::WAIT_ZERO);
    wire beat_end   = active && (rdy || wait_exp);
    wire abort      = active && (berr || tmr_expired);
    wire last_beat  = !gmode_q || (beat_q == lbus_pkg::GATHER_LAST);
    wire [7:0] rbyte = bus_rdata[lbus_pkg::BYTE_W-1:0];

    always_comb begin
        state_d  = state_q;
        wcnt_d   = wcnt_q;
        beat_d   = beat_q;
        gather_d = gather_q;
        addr_d   = addr_q;
        rsp_d    = rsp_q;
        unique case (state_q)
            ST_IDLE: begin
                if (req_valid) begin
                    state_d = ST_BUS;
                    wcnt_d  = wait_q;
                    beat_d  = 2'h0;
                    addr_d  = req.addr;
                    rsp_d   = '0;
                end
            end
            ST_BUS: begin
                if (abort) begin
                    state_d         = ST_DONE;
                    rsp_d.bus_error = 1'b1;
                    rsp_d.timeout   = tmr_expired;
                end else if (beat_end) begin
                    if (gmode_q) begin
                        gather_d = {rbyte, gather_q[31:8]};
                    end else begin
                        rsp_d.rdata = bus_rdata;
                    end
                    if (last_beat) begin
                        state_d = ST_DONE;
                        if (gmode_q) begin
                            rsp_d.rdata = {rbyte, gather_q[31:8]};
                        end
                    end else begin
                        beat_d = beat_q + lbus_pkg::ONE_2;
                        addr_d = addr_q + 32'h0000_0001;
                        wcnt_d = wait_q;
                    end
                end else if (wcnt_q != lbus_pkg::WAIT_ZERO) begin
                    wcnt_d = wcnt_q - 4'h1;
                end
            end
            ST_DONE: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q  <= ST_IDLE;
            wait_q   <= lbus_pkg::WAIT_RESET;
            wcnt_q   <= lbus_pkg::WAIT_RESET;
            beat_q   <= 2'h0;
            gather_q <= 32'h0000_0000;
            addr_q   <= 32'h0000_0000;
            rsp_q    <= '0;
            gmode_q  <= 1'b0;
        end else if (clk_en) begin
            state_q  <= state_d;
            wcnt_q   <= wcnt_d;
            beat_q   <= beat_d;
            gather_q <= gather_d;
            addr_q   <= addr_d;
            rsp_q    <= rsp_d;
            if (wait_wr) begin
                wait_q <= wait_val;
            end
            if (start) begin
                gmode_q <= gather_req;
            end
        end
    end

    bus_timer u_timer (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .start   (start || (beat_end && !last_beat)),
        .active  (active),
        .tmo_en  (!timeout_en_n),
        .expired (tmr_expired)
    );

    assign req_done         = (state_q == ST_DONE);
    assign rsp              = rsp_q;
    assign wait_count       = wait_q;
    assign bus_addr         = addr_q;
    assign bus_wdata        = req.wdata;
    assign bus_data_oe      = active && req.write;
    assign lane_we          = (active && req.write) ?
                              lane_mask(req.size, addr_q[1:0], req.little) : 4'h0;
    assign address_strobe_n = !active;
    assign bus_write        = req.write;
    assign ifetch_access    = req.ifetch;
    assign rd_oe_n          = !(active && !req.write);
    assign chip_sel_n.boot  = !in_space(addr_q, lbus_pkg::SPACE_BOOT);
    assign chip_sel_n.io    = !in_space(addr_q, lbus_pkg::SPACE_IO);
    assign chip_sel_n.glob  = !in_space(addr_q, lbus_pkg::SPACE_GLOB);
    assign bus_timeout      = tmr_expired;
    assign timeout_exc      = tmr_expired;
endmodule // lbus_engine
`default_nettype wire

/* File: verification/lbus_checker.sv */
// Concurrent checks on the local bus engine ports.
// Assumes one clock domain and a bind into every engine instance.
`timescale 1ns/100ps
`default_nettype none
module lbus_checker (
    input wire logic                  ref_clk,          // Clock.
    input wire logic                  rst_n,            // Reset, low.
    input wire logic                  clk_en,           // Run enable.
    input wire lbus_pkg::access_req_t req,              // Request.
    input wire logic                  req_done,         // Done pulse.
    input wire lbus_pkg::access_rsp_t rsp,              // Result.
    input wire logic                  wait_wr,          // Wait load.
    input wire logic [3:0]            wait_val,         // Wait value.
    input wire logic [3:0]            wait_count,       // Wait count.
    input wire logic [31:0]           bus_addr,         // Address.
    input wire logic [3:0]            lane_we,          // Lanes.
    input wire logic                  address_strobe_n, // Strobe, low.
    input wire logic                  bus_write,        // Write.
    input wire lbus_pkg::chip_sel_t   chip_sel_n,       // Selects, low.
    input wire logic                  data_ready_n,     // Ready, low.
    input wire logic                  wait_en_n,        // Wait enable, low.
    input wire logic                  bus_error_n,      // Error, low.
    input wire logic                  timeout_en_n,     // Timer enable, low.
    input wire logic                  byte_wide,        // Byte-wide.
    input wire logic                  bus_timeout,      // Timeout pin.
    input wire logic                  timeout_exc       // Timeout exception.
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n || !clk_en);
    sequence s_wait_start;
        $fell(address_strobe_n) && !wait_en_n && !byte_wide;
    endsequence
    a_wait_reset: assert property ($rose(rst_n) |-> wait_count == 4'hf)
        else $error("wait count not at reset value");
    a_wait_load: assert property (wait_wr |=> wait_count == $past(wait_val))
        else $error("wait count not loaded");
    a_sel_decode: assert property (
        chip_sel_n == {bus_addr[31:29] != 3'h0, bus_addr[31:29] != 3'h1,
        bus_addr[31:29] != 3'h2})
        else $error("chip select decode wrong");
    a_lane_word: assert property (
        !address_strobe_n && bus_write && req.size == lbus_pkg::SZ_WORD
        |-> lane_we == 4'hf)
        else $error("word write lanes wrong");
    a_tmo_gate: assert property (
        timeout_exc || bus_timeout |-> !timeout_en_n && bus_timeout == timeout_exc)
        else $error("timeout not gated");
    a_ready_ends: assert property (
        !address_strobe_n && !data_ready_n && (!byte_wide || bus_write) |=> req_done)
        else $error("ready did not end access");
    a_error_ends: assert property (
        !address_strobe_n && !bus_error_n |=> req_done && rsp.bus_error)
        else $error("error did not end access");
    a_wait_zero: assert property (s_wait_start ##0 wait_count == 4'h0 |=> req_done)
        else $error("zero wait not shortest");
    a_wait_bound: assert property (s_wait_start |-> ##[1:17] req_done)
        else $error("wait expiry missed");
endmodule // lbus_checker
bind lbus_engine lbus_checker chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .req(req), .req_done(req_done), .rsp(rsp), .wait_wr(wait_wr), .wait_val(wait_val),
    .wait_count(wait_count), .bus_addr(bus_addr), .lane_we(lane_we),
    .address_strobe_n(address_strobe_n), .bus_write(bus_write), .chip_sel_n(chip_sel_n),
    .data_ready_n(data_ready_n), .wait_en_n(wait_en_n), .bus_error_n(bus_error_n),
    .timeout_en_n(timeout_en_n), .byte_wide(byte_wide), .bus_timeout(bus_timeout),
    .timeout_exc(timeout_exc));
`default_nettype wire

/* File: verification/mem_model.sv */
// Memory or I/O device on the local bus, answering reads and handshakes.
// Assumes the bench picks ready or error answers per access.
`timescale 1ns/100ps
`default_nettype none
module mem_model (
    input wire logic        ref_clk,          // Clock.
    input wire logic        rdy_en,           // Answer with ready.
    input wire logic        err_en,           // Answer with error.
    input wire logic        address_strobe_n, // Strobe, low.
    input wire logic        rd_oe_n,          // Read enable, low.
    input wire logic        byte_wide,        // Byte-wide device.
    input wire logic [31:0] bus_addr,         // Address.
    output logic [31:0]     bus_rdata,        // Read data.
    output logic            data_ready_n,     // Ready, low.
    output logic            bus_error_n       // Error, low.
);
    logic [31:0] junk_q = 32'h5a5a_5a5a;
    // Released lines move every cycle so stale data cannot pass as a match.
    always_ff @(posedge ref_clk) begin
        junk_q <= junk_q + 32'h0101_0101;
    end
    assign bus_rdata = rd_oe_n ? junk_q : byte_wide ? {24'hff_ffff, bus_addr[7:0]}
        : {bus_addr[15:0], ~bus_addr[15:0]};
    assign data_ready_n = !(rdy_en && !address_strobe_n);
    assign bus_error_n = !(err_en && !address_strobe_n);
endmodule // mem_model
`default_nettype wire

/* File: verification/tb_lbus_engine.sv */
// Self-checking bench for the local bus engine with a device model.
// Assumes a 10 MHz clock and the design's hand-over timing.
`timescale 1ns/100ps
`default_nettype none
module tb_lbus_engine;
    logic ref_clk = 0, rst_n = 0, req_valid = 0, wait_wr = 0, wait_en_n = 1;
    logic timeout_en_n = 1, byte_wide = 0, rdy_en = 1, err_en = 0;
    logic [3:0] wait_val = 4'h0, wait_count, lane_we, lw;
    logic [1:0] tmo;
    lbus_pkg::access_req_t req = '0;
    lbus_pkg::access_rsp_t rsp;
    lbus_pkg::chip_sel_t chip_sel_n, cs;
    logic [31:0] bus_addr, bus_wdata, bus_rdata, wd;
    logic req_done, bus_data_oe, address_strobe_n, bus_write, ifetch_access, rd_oe_n;
    logic data_ready_n, bus_error_n, bus_timeout, timeout_exc;
    logic [7:0] tab [9] = '{8'hcf, 8'h87, 8'h9e, 8'h43, 8'h6c, 8'h01, 8'h12, 8'h24, 8'h38};
    int fail_count = 0, tests_run = 0, n, k, l;
    always #50 ref_clk = ~ref_clk;
    lbus_engine dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1), .req_valid(req_valid),
        .req(req), .req_done(req_done), .rsp(rsp), .wait_wr(wait_wr), .wait_val(wait_val),
        .wait_count(wait_count), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_data_oe(bus_data_oe), .bus_rdata(bus_rdata), .lane_we(lane_we),
        .address_strobe_n(address_strobe_n), .bus_write(bus_write),
        .ifetch_access(ifetch_access), .rd_oe_n(rd_oe_n), .chip_sel_n(chip_sel_n),
        .data_ready_n(data_ready_n), .wait_en_n(wait_en_n), .bus_error_n(bus_error_n),
        .timeout_en_n(timeout_en_n), .byte_wide(byte_wide), .bus_timeout(bus_timeout),
        .timeout_exc(timeout_exc));
    mem_model mem (.ref_clk(ref_clk), .rdy_en(rdy_en), .err_en(err_en),
        .address_strobe_n(address_strobe_n), .rd_oe_n(rd_oe_n), .byte_wide(byte_wide),
        .bus_addr(bus_addr), .bus_rdata(bus_rdata), .data_ready_n(data_ready_n),
        .bus_error_n(bus_error_n));
    function automatic logic [3:0] rev4(input logic [3:0] m);
        return {m[0], m[1], m[2], m[3]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Runs one access; counts strobe-low cycles and keeps the lanes and selects seen.
    task automatic access(input logic [31:0] a, input logic w, input logic [1:0] sz,
                          input logic lt, input logic d);
        int i;
        n = 0;
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req <= '{addr: a, write: w, dma: d, cached: 1'b0, ifetch: 1'b0,
                 size: lbus_pkg::access_size_t'(sz), little: lt, wdata: 32'h1234_5678};
        // Outputs are read mid-cycle, where they have settled after the edge.
        for (i = 0; i < 70000; i++) begin
            @(negedge ref_clk);
            if (address_strobe_n === 1'b0) begin
                n++;
                lw = lane_we;
                cs = chip_sel_n;
                wd = bus_data_oe ? bus_wdata : 32'h0;
                tmo = {bus_timeout, timeout_exc};
            end
            if (req_done === 1'b1) break;
        end
        @(posedge ref_clk);
        req_valid <= 1'b0;
        if (i == 70000) begin
            chk(32'h0, 32'h1, "access never finished");
            print_verdict;
        end
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        chk(wait_count, 32'hf, "reset wait count");
        chk(chip_sel_n, 32'h3, "idle boot select");
        for (k = 0; k < 9; k++) for (l = 0; l < 2; l++) begin
            access({30'h1000_0040, tab[k][5:4]}, 1'b1, tab[k][7:6], l[0], 1'b0);
            chk(lw, l ? rev4(tab[k][3:0]) : tab[k][3:0], "write lanes");
            chk(cs, 32'h6, "global select");
            chk(wd, 32'h1234_5678, "write data driven");
        end
        access(32'h2000_0010, 1'b0, 2'h1, 1'b0, 1'b0);
        chk(rsp.rdata, 32'h0010_ffef, "half read word");
        chk(cs, 32'h5, "io select");
        access(32'h0000_0020, 1'b0, 2'h3, 1'b0, 1'b0);
        chk(cs, 32'h3, "boot select");
        rdy_en <= 1'b0;
        wait_en_n <= 1'b0;
        access(32'h4000_0000, 1'b0, 2'h3, 1'b0, 1'b0);
        chk(n, 32'd16, "fifteen waits");
        for (k = 0; k < 2; k++) begin
            wait_wr <= 1'b1;
            wait_val <= 4'(k * 7);
            @(posedge ref_clk);
            wait_wr <= 1'b0;
            access(32'h4000_0000, 1'b0, 2'h3, 1'b0, 1'b0);
            chk(n, k * 7 + 1, "programmed waits");
        end
        rdy_en <= 1'b1;
        access(32'h4000_0000, 1'b0, 2'h3, 1'b0, 1'b0);
        chk(n, 32'd1, "early ready");
        rdy_en <= 1'b0;
        err_en <= 1'b1;
        access(32'h4000_0000, 1'b1, 2'h3, 1'b0, 1'b0);
        chk(n, 32'd1, "bus error length");
        chk(rsp.bus_error, 32'h1, "bus error end");
        err_en <= 1'b0;
        wait_en_n <= 1'b1;
        rdy_en <= 1'b1;
        byte_wide <= 1'b1;
        access(32'h0000_0102, 1'b0, 2'h0, 1'b0, 1'b0);
        chk(rsp.rdata, 32'h0504_0302, "gathered word");
        access(32'h0000_0102, 1'b0, 2'h0, 1'b0, 1'b1);
        chk(rsp.rdata, 32'hffff_ff02, "dma not gathered");
        access(32'h0000_0101, 1'b1, 2'h3, 1'b0, 1'b0);
        chk(n, 32'd1, "write single beat");
        chk(lw, 32'hf, "write not scattered");
        byte_wide <= 1'b0;
        rdy_en <= 1'b0;
        timeout_en_n <= 1'b0;
        access(32'h4000_0000, 1'b0, 2'h3, 1'b0, 1'b0);
        chk({rsp.timeout, rsp.bus_error}, 32'h3, "timeout end");
        chk(n > 65000, 32'h1, "timer full length");
        chk(tmo, 32'h3, "timeout pin and exception");
        print_verdict;
    end
endmodule // tb_lbus_engine
`default_nettype wire
